// ---- hw/uepd_portal.sv ----
// Purpose: Endpoint buffer portal for the processor and two DMA channels
// Assumes: Register port strobes one cycle long, never both at once
// Notes: DMA portal writes pass a 16-entry FIFO into buffer memory
`timescale 1ns/1ns
module uepd_portal
	import uepd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// System DMA side
	input wire logic dma_chan,
	input wire logic [1:0] dma_done,
	output logic [1:0] dma_req,
	output logic dma_portal_ready
);

	// Address decode
	logic sel_sa;
	logic sel_sd;
	logic sel_ctrl;
	logic sel_dma0;
	logic sel_dma1;
	logic sel_portal;

	always_comb
	begin
		sel_sa = 1'b0;
		sel_sd = 1'b0;
		sel_ctrl = 1'b0;
		sel_dma0 = 1'b0;
		sel_dma1 = 1'b0;
		sel_portal = 1'b0;
		if (reg_addr == UEPD_SUBADDR_OFS)
			sel_sa = 1'b1;
		else if (reg_addr == UEPD_SUBDATA_OFS)
			sel_sd = 1'b1;
		else if (reg_addr == UEPD_CTRL_OFS)
			sel_ctrl = 1'b1;
		else if (reg_addr == UEPD_DMA0_OFS)
			sel_dma0 = 1'b1;
		else if (reg_addr == UEPD_DMA1_OFS)
			sel_dma1 = 1'b1;
		else if (reg_addr == UEPD_PORTAL_OFS)
			sel_portal = 1'b1;
	end

	// Processor access control
	logic inhibit_q;
	logic [2:0] ep_choice_q;
	logic space_q;
	logic [6:0] sa_q;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			inhibit_q <= UEPD_CTRL_RST[UEPD_INHIBIT_BIT];
			ep_choice_q <= UEPD_CTRL_RST[UEPD_EP_MSB:UEPD_EP_LSB];
		end
		else if (reg_wr && sel_ctrl)
		begin
			inhibit_q <= reg_wdata[UEPD_INHIBIT_BIT];
			ep_choice_q <= reg_wdata[UEPD_EP_MSB:UEPD_EP_LSB];
		end
	end

	// Subdata buffer access and its auto-increment
	logic sd_buf;
	logic sd_wr_buf;
	logic sd_step;
	logic [UEPD_MEM_AW-1:0] sd_addr;

	assign sd_buf = space_q;
	assign sd_wr_buf = reg_wr && sel_sd && sd_buf;
	assign sd_addr = {ep_choice_q, sa_q[UEPD_PTR_W-1:0]};
	// OUT buffers step on read, IN buffers on write
	assign sd_step = sel_sd && sd_buf && !inhibit_q
		&& (ep_choice_q[UEPD_OUT_BIT] ? reg_rd : reg_wr);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			space_q <= UEPD_SA_RST[UEPD_SPACE_BIT];
			sa_q <= UEPD_SA_RST[UEPD_SA_TOP_BIT:0];
		end
		else if (reg_wr && sel_sa)
		begin
			space_q <= reg_wdata[UEPD_SPACE_BIT];
			sa_q <= {reg_wdata[UEPD_SA_TOP_BIT] && !reg_wdata[UEPD_SPACE_BIT],
				reg_wdata[UEPD_SA_TOP_BIT-1:0]};
		end
		else if (sd_step)
			sa_q <= {1'b0, sa_q[UEPD_PTR_W-1:0] + 6'h01};
	end

	// DMA channels
	logic [2:0] ch_ep [0:1];
	logic [5:0] ch_ptr [0:1];
	logic [7:0] ch_rd [0:1];
	logic [1:0] ch_go;
	logic [1:0] ch_step;
	logic [1:0] ch_wr;
	logic fifo_in_ready;
	logic dma_wr;
	logic dma_rd;

	assign dma_wr = reg_wr && sel_portal;
	assign dma_rd = reg_rd && sel_portal;
	assign ch_wr = {reg_wr && sel_dma1, reg_wr && sel_dma0};

	// A refused write leaves the pointer where it was
	always_comb
	begin
		ch_step = 2'h0;
		ch_step[dma_chan] = dma_rd || (dma_wr && fifo_in_ready);
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			uepd_dma_chan u_chan (
				.ref_clk(ref_clk),
				.reset(reset),
				.ctrl_wr(ch_wr[gi]),
				.ctrl_wdata(reg_wdata),
				.step(ch_step[gi]),
				.done(dma_done[gi]),
				.ep(ch_ep[gi]),
				.go(ch_go[gi]),
				.ptr(ch_ptr[gi]),
				.ctrl_rd(ch_rd[gi])
			);
		end
	endgenerate

	assign dma_req = ch_go;

	// Portal write path through the FIFO
	uepd_wr_s fifo_in;
	uepd_wr_s fifo_out;
	logic fifo_out_valid;
	logic fifo_out_ready;

	assign fifo_in.ep = ch_ep[dma_chan];
	assign fifo_in.ptr = ch_ptr[dma_chan];
	assign fifo_in.data = reg_wdata;
	// Processor subdata writes own the memory port first
	assign fifo_out_ready = !sd_wr_buf;

	uepd_fifo #(
		.WIDTH(UEPD_WR_W),
		.DEPTH(UEPD_FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(dma_wr),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			dma_portal_ready <= 1'b1;
		else
			dma_portal_ready <= fifo_in_ready;
	end

	// Endpoint buffer memory, eight buffers of 64 bytes
	logic [7:0] mem_q [0:UEPD_MEM_BYTES-1];

	always_ff @(posedge ref_clk)
	begin
		if (sd_wr_buf)
			mem_q[sd_addr] <= reg_wdata;
		else if (fifo_out_valid)
			mem_q[{fifo_out.ep, fifo_out.ptr}] <= fifo_out.data;
	end

	// Read data, present only in the cycle after a read
	logic [7:0] rdata_d;
	logic [7:0] dma_byte;

	assign dma_byte = mem_q[{ch_ep[dma_chan], ch_ptr[dma_chan]}];

	always_comb
	begin
		rdata_d = 8'h00;
		if (!reg_rd)
			rdata_d = 8'h00;
		else if (sel_sa)
			rdata_d = {space_q, sa_q};
		else if (sel_sd)
			rdata_d = sd_buf ? mem_q[sd_addr] : 8'h00;
		else if (sel_ctrl)
			rdata_d = {1'b0, inhibit_q, ep_choice_q, 3'h0};
		else if (sel_dma0)
			rdata_d = ch_rd[0];
		else if (sel_dma1)
			rdata_d = ch_rd[1];
		else if (sel_portal)
			rdata_d = dma_byte;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= UEPD_PORTAL_RST;
		else
			reg_rdata <= rdata_d;
	end

	// Checks
	property p_sd_inc;
		@(posedge ref_clk) disable iff (reset)
		sd_step |=> sa_q[5:0] == $past(sa_q[5:0]) + 6'h01;
	endproperty
	a_sd_inc: assert property (p_sd_inc)
		else $error("subaddress did not advance on buffer access");

	property p_sd_hold;
		@(posedge ref_clk) disable iff (reset)
		sel_sd && (reg_rd || reg_wr) && inhibit_q |=> sa_q == $past(sa_q);
	endproperty
	a_sd_hold: assert property (p_sd_hold)
		else $error("subaddress moved while increment inhibited");

	property p_portal_read;
		@(posedge ref_clk) disable iff (reset)
		dma_rd |=> reg_rdata == $past(dma_byte);
	endproperty
	a_portal_read: assert property (p_portal_read)
		else $error("portal read returned wrong byte");

	property p_other_chan;
		@(posedge ref_clk) disable iff (reset)
		(dma_rd || dma_wr) && !ch_wr[!dma_chan]
		|=> ch_ptr[!$past(dma_chan)] == $past(ch_ptr[!dma_chan]);
	endproperty
	a_other_chan: assert property (p_other_chan)
		else $error("portal access moved the other channel pointer");

	property p_idle_rdata;
		@(posedge ref_clk) disable iff (reset)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_idle_rdata: assert property (p_idle_rdata)
		else $error("read data not zero after a non-read cycle");

	// Subdata access in the direction that does not step holds position
	property p_sd_dir_hold;
		@(posedge ref_clk) disable iff (reset)
		sel_sd && sd_buf
		&& (ep_choice_q[UEPD_OUT_BIT] ? reg_wr : reg_rd)
		|=> sa_q == $past(sa_q);
	endproperty
	a_sd_dir_hold: assert property (p_sd_dir_hold)
		else $error("subaddress moved on a non-stepping access");

	property p_sa_force;
		@(posedge ref_clk) disable iff (reset)
		reg_wr && sel_sa && reg_wdata[UEPD_SPACE_BIT]
		|=> space_q && !sa_q[UEPD_SA_TOP_BIT];
	endproperty
	a_sa_force: assert property (p_sa_force)
		else $error("subaddress top bit not cleared in buffer space");

	property p_sfr_read;
		@(posedge ref_clk) disable iff (reset)
		reg_rd && sel_sd && !space_q |=> reg_rdata == 8'h00;
	endproperty
	a_sfr_read: assert property (p_sfr_read)
		else $error("subdata read outside buffer space not zero");

	property p_sd_store;
		@(posedge ref_clk) disable iff (reset)
		sd_wr_buf |=> mem_q[$past(sd_addr)] == $past(reg_wdata);
	endproperty
	a_sd_store: assert property (p_sd_store)
		else $error("subdata write did not reach the buffer");

	property p_fifo_store;
		@(posedge ref_clk) disable iff (reset)
		fifo_out_valid && fifo_out_ready
		|=> mem_q[$past({fifo_out.ep, fifo_out.ptr})]
			== $past(fifo_out.data);
	endproperty
	a_fifo_store: assert property (p_fifo_store)
		else $error("queued portal write did not reach the buffer");

	property p_portal_step;
		@(posedge ref_clk) disable iff (reset)
		dma_rd
		|=> ch_ptr[$past(dma_chan)] == $past(ch_ptr[dma_chan]) + 6'h01;
	endproperty
	a_portal_step: assert property (p_portal_step)
		else $error("portal read did not advance its channel pointer");

	property p_drop_hold;
		@(posedge ref_clk) disable iff (reset)
		dma_wr && !fifo_in_ready
		|=> ch_ptr[$past(dma_chan)] == $past(ch_ptr[dma_chan]);
	endproperty
	a_drop_hold: assert property (p_drop_hold)
		else $error("refused portal write moved the pointer");

	property p_ctrl_zeros;
		@(posedge ref_clk) disable iff (reset)
		reg_rd && sel_ctrl |=> !reg_rdata[7] && reg_rdata[2:0] == 3'h0;
	endproperty
	a_ctrl_zeros: assert property (p_ctrl_zeros)
		else $error("reserved control bits read back nonzero");

	c_both: cover property (@(posedge ref_clk) disable iff (reset)
		ch_go == 2'h3);
	c_full: cover property (@(posedge ref_clk) disable iff (reset)
		dma_wr && !fifo_in_ready);
	c_wrap: cover property (@(posedge ref_clk) disable iff (reset)
		sd_step && sa_q[5:0] == 6'h3F);

endmodule : uepd_portal

// ---- hw/uepd_pkg.sv ----
// Purpose: Shared constants and types of the endpoint buffer DMA portal
// Assumes: 8-bit register port with 12-bit byte addresses
// Notes: All offsets are byte addresses on the register port
package uepd_pkg;

	// Register offsets
	localparam logic [11:0] UEPD_SUBADDR_OFS = 12'hF59;
	localparam logic [11:0] UEPD_SUBDATA_OFS = 12'hF5A;
	localparam logic [11:0] UEPD_CTRL_OFS = 12'hF5B;
	localparam logic [11:0] UEPD_DMA0_OFS = 12'hF5C;
	localparam logic [11:0] UEPD_DMA1_OFS = 12'hF5D;
	localparam logic [11:0] UEPD_PORTAL_OFS = 12'hF5E;

	// Field positions
	localparam int UEPD_SPACE_BIT = 7;
	localparam int UEPD_SA_TOP_BIT = 6;
	localparam int UEPD_INHIBIT_BIT = 6;
	localparam int UEPD_EP_LSB = 3;
	localparam int UEPD_EP_MSB = 5;
	localparam int UEPD_OUT_BIT = 2;
	localparam int UEPD_GO_BIT = 0;

	// Reset values
	localparam logic [7:0] UEPD_CTRL_RST = 8'h00;
	localparam logic [7:0] UEPD_DMA_RST = 8'h00;
	localparam logic [7:0] UEPD_SA_RST = 8'h00;
	localparam logic [7:0] UEPD_PORTAL_RST = 8'h00;

	// Sizes
	localparam int UEPD_PTR_W = 6;
	localparam int UEPD_EP_W = 3;
	localparam int UEPD_MEM_AW = 9;
	localparam int UEPD_MEM_BYTES = 512;
	localparam int UEPD_FIFO_DEPTH = 16;

	// Pending DMA write into a buffer
	typedef struct packed {
		logic [2:0] ep;
		logic [5:0] ptr;
		logic [7:0] data;
	} uepd_wr_s;

	localparam int UEPD_WR_W = $bits(uepd_wr_s);

endpackage : uepd_pkg

// ---- hw/uepd_fifo.sv ----
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: One clock, asynchronous active-high reset
// Notes: Full and empty come from pointers with one extra wrap bit
`timescale 1ns/1ns
module uepd_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_q [0:DEPTH-1];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data = store_q[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			wr_q <= '0;
		else if (push)
			wr_q <= wr_q + 1'b1;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			rd_q <= '0;
		else if (pop)
			rd_q <= rd_q + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
			store_q[wr_q[AW-1:0]] <= in_data;
	end

	cover property (@(posedge ref_clk) disable iff (reset) !in_ready);

endmodule : uepd_fifo

// ---- hw/uepd_dma_chan.sv ----
// Purpose: One DMA channel: control register, request and byte pointer
// Assumes: Done is a one-cycle pulse from the system DMA controller
// Notes: A software write in the same cycle as done takes precedence
`timescale 1ns/1ns
module uepd_dma_chan
	import uepd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register write
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	// Portal traffic
	input wire logic step,
	input wire logic done,
	// State
	output logic [2:0] ep,
	output logic go,
	output logic [5:0] ptr,
	output logic [7:0] ctrl_rd
);

	logic [2:0] ep_q;
	logic go_q;
	logic [5:0] ptr_q;

	assign ep = ep_q;
	assign go = go_q;
	assign ptr = ptr_q;
	assign ctrl_rd = {2'h0, ep_q, 2'h0, go_q};

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			ep_q <= UEPD_DMA_RST[UEPD_EP_MSB:UEPD_EP_LSB];
			go_q <= UEPD_DMA_RST[UEPD_GO_BIT];
		end
		else if (ctrl_wr)
		begin
			ep_q <= ctrl_wdata[UEPD_EP_MSB:UEPD_EP_LSB];
			go_q <= ctrl_wdata[UEPD_GO_BIT];
		end
		else if (done)
			go_q <= 1'b0;
	end

	// Pointer restarts at byte 0 on start and wraps at 64
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			ptr_q <= '0;
		else if (ctrl_wr && ctrl_wdata[UEPD_GO_BIT])
			ptr_q <= '0;
		else if (step)
			ptr_q <= ptr_q + 6'h01;
	end

	property p_go_start;
		@(posedge ref_clk) disable iff (reset)
		ctrl_wr && ctrl_wdata[UEPD_GO_BIT] |=> go_q && (ptr_q == 6'h00);
	endproperty
	a_go_start: assert property (p_go_start)
		else $error("start write did not raise request at byte 0");

	property p_done_clears;
		@(posedge ref_clk) disable iff (reset)
		done && !ctrl_wr |=> !go_q;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("request stayed up after done");

	property p_sw_clear;
		@(posedge ref_clk) disable iff (reset)
		ctrl_wr && !ctrl_wdata[UEPD_GO_BIT] |=> !go_q;
	endproperty
	a_sw_clear: assert property (p_sw_clear)
		else $error("software clear did not drop request");

	property p_ptr_step;
		@(posedge ref_clk) disable iff (reset)
		step && !ctrl_wr |=> ptr_q == $past(ptr_q) + 6'h01;
	endproperty
	a_ptr_step: assert property (p_ptr_step)
		else $error("pointer did not advance by one");

	property p_ptr_wrap;
		@(posedge ref_clk) disable iff (reset)
		step && !ctrl_wr && ptr_q == 6'h3F |=> ptr_q == 6'h00;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap)
		else $error("pointer did not wrap to zero");

	c_done: cover property (@(posedge ref_clk) disable iff (reset)
		go_q ##1 done ##1 !go_q);

endmodule : uepd_dma_chan

// ---- tb/uepd_dma_model.sv ----
// Purpose: System DMA controller stand-in that ends transfers
// Assumes: The bench makes the portal accesses on the register port
// Notes: Done pulses once a requesting channel made xfer_len accesses
`timescale 1ns/1ns
module uepd_dma_model
	import uepd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Observed traffic
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic dma_chan,
	input wire logic [1:0] dma_req,
	input wire logic [7:0] xfer_len,
	// Completion
	output logic [1:0] dma_done
);
	logic hit;
	logic [7:0] cnt_q [2];

	assign hit = (reg_rd | reg_wr) && (reg_addr == UEPD_PORTAL_OFS);

	// One count per channel, so both may run at once
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			cnt_q[0] <= 8'h00;
			cnt_q[1] <= 8'h00;
			dma_done <= 2'h0;
		end
		else
		begin
			dma_done <= 2'h0;
			for (int c = 0; c < 2; c++)
			begin
				if (!dma_req[c])
					cnt_q[c] <= 8'h00;
				else if (hit && dma_chan == c)
				begin
					if (cnt_q[c] == xfer_len - 8'h01)
					begin
						dma_done[c] <= 1'b1;
						cnt_q[c] <= 8'h00;
					end
					else
						cnt_q[c] <= cnt_q[c] + 8'h01;
				end
			end
		end
	end
endmodule : uepd_dma_model

// ---- tb/uepd_portal_bench.sv ----
// Purpose: Self-checking bench of the endpoint buffer DMA portal
// Assumes: Register accesses leave one idle cycle between them
// Notes: Channel 1 writes OUT 0, channel 0 reads IN 0 in between
`timescale 1ns/1ns
module uepd_portal_bench;
	import uepd_pkg::*;

	logic ref_clk;
	logic reset;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic dma_chan;
	logic [1:0] dma_done;
	logic [1:0] dma_req;
	logic dma_portal_ready;
	int failures = 0;
	int checks_done = 0;

	uepd_portal i_uepd_portal (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_chan(dma_chan),
		.dma_done(dma_done), .dma_req(dma_req),
		.dma_portal_ready(dma_portal_ready));

	uepd_dma_model i_uepd_dma_model (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.dma_chan(dma_chan), .dma_req(dma_req), .xfer_len(8'h41),
		.dma_done(dma_done));

	always #20 ref_clk = ~ref_clk;

	task automatic conclude();
		$display("Checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h saw %h", what, exp, got);
		end
	endtask : check

	task automatic acc(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic c, output logic [7:0] q);
		reg_addr <= a;
		reg_wdata <= d;
		dma_chan <= c;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
		@(posedge ref_clk);
	endtask : acc

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, 1'b1, q);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic c,
		input logic [7:0] exp, input string what);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, c, q);
		check(what, exp, q);
	endtask : rdchk

	task automatic req_is(input logic [1:0] exp);
		#1;
		check("dma_req", {6'h00, exp}, {6'h00, dma_req});
		@(posedge ref_clk);
	endtask : req_is

	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		dma_chan = 1'b0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		// Reset values and an unmapped address
		rdchk(UEPD_CTRL_OFS, 1'b0, UEPD_CTRL_RST, "ctrl rst");
		rdchk(UEPD_DMA0_OFS, 1'b0, UEPD_DMA_RST, "dma0 rst");
		rdchk(UEPD_DMA1_OFS, 1'b0, UEPD_DMA_RST, "dma1 rst");
		rdchk(12'h123, 1'b0, 8'h00, "unmapped");
		req_is(2'h0);
		wr(UEPD_CTRL_OFS, 8'h78);
		rdchk(UEPD_CTRL_OFS, 1'b0, 8'h78, "ctrl");
		// Subdata outside buffer space is ignored and reads zero
		wr(UEPD_SUBADDR_OFS, 8'h00);
		wr(UEPD_SUBDATA_OFS, 8'h5A);
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h00, "sfr");
		// Fill IN 0 through the subdata portal
		wr(UEPD_SUBADDR_OFS, 8'h80);
		wr(UEPD_CTRL_OFS, 8'h00);
		for (int i = 0; i < 4; i++)
			wr(UEPD_SUBDATA_OFS, 8'hA0 + 8'(i));
		// IN buffer reads keep the subdata position
		wr(UEPD_SUBADDR_OFS, 8'h81);
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'hA1, "in rd a");
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'hA1, "in rd b");
		// Both channels running at once
		wr(UEPD_DMA0_OFS, 8'h01);
		rdchk(UEPD_DMA0_OFS, 1'b0, 8'h01, "dma0");
		wr(UEPD_DMA1_OFS, 8'h21);
		req_is(2'h3);
		for (int i = 0; i < 65; i++)
		begin
			wr(UEPD_PORTAL_OFS, 8'h10 + 8'(i));
			if (i < 4)
				rdchk(UEPD_PORTAL_OFS, 1'b0, 8'hA0 + 8'(i), "ch0");
		end
		#1;
		check("ready", 8'h01, {7'h00, dma_portal_ready});
		req_is(2'h1);
		rdchk(UEPD_DMA1_OFS, 1'b0, 8'h20, "dma1 done");
		wr(UEPD_DMA0_OFS, 8'h00);
		req_is(2'h0);
		// Read OUT 0 back; byte 0 was rewritten after the wrap
		wr(UEPD_CTRL_OFS, 8'h20);
		wr(UEPD_SUBADDR_OFS, 8'h80);
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h50, "wrap");
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h11, "out1");
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h12, "out2");
		// Fixed address holds the subdata position
		wr(UEPD_CTRL_OFS, 8'h60);
		wr(UEPD_SUBADDR_OFS, 8'h81);
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h11, "fix a");
		rdchk(UEPD_SUBDATA_OFS, 1'b0, 8'h11, "fix b");
		// Restarts begin again at byte 0
		wr(UEPD_DMA0_OFS, 8'h01);
		rdchk(UEPD_PORTAL_OFS, 1'b0, 8'hA0, "ch0 again");
		wr(UEPD_DMA1_OFS, 8'h01);
		rdchk(UEPD_PORTAL_OFS, 1'b1, 8'hA0, "ch1 again");
		conclude();
	end

	initial
	begin
		#100000;
		failures++;
		conclude();
	end
endmodule : uepd_portal_bench
